// [hw/pllcd_clock_config.v]
// PLL factor and clock divider configuration registers with the divider chain they steer.
// Assumes a host register port that is synchronous to mclk; one write or read per cycle.
`timescale 1ns/1ps
`include "pllcd_defs.vh"

module pllcd_clock_config #(
	parameter [6:0]  AUTO_DSP_DIV   = 7'h01,
	parameter [6:0]  AUTO_CONV_DIV  = 7'h01,
	parameter [6:0]  AUTO_CP_DIV    = 7'h03,
	parameter [6:0]  AUTO_OSR_DIV   = 7'h01,
	parameter [6:0]  AUTO_BCLK_DIV  = 7'h07,
	parameter [7:0]  AUTO_FCLK_DIV  = 8'h3F,
	parameter [3:0]  AUTO_POST_MULT = 4'h0,
	parameter [13:0] AUTO_FRAC      = 14'h0000
) (
	input  wire        mclk,
	input  wire        reset,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	input  wire        auto_clock_setting_disable,
	input  wire        master_mode,
	input  wire        src_clk_en,
	input  wire [5:0]  pll_integer_mult,
	input  wire [3:0]  pll_pre_divide,
	input  wire [5:0]  auto_integer_mult,
	input  wire [3:0]  auto_pre_divide,
	output reg  [5:0]  eff_integer_mult,
	output reg  [4:0]  eff_pre_divide,
	output reg  [4:0]  eff_post_mult,
	output reg  [13:0] eff_fraction,
	output reg         fraction_illegal,
	output reg  [31:0] pll_mult_x10000,
	output reg         dsp_clk_en,
	output reg         converter_clk_en,
	output reg         charge_pump_clk_en,
	output reg         oversample_clk_en,
	output reg         master_bitclk,
	output reg         master_frameclk
);

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg [5:0] frac_high_q;
	reg [7:0] frac_low_q;
	reg [3:0] post_mult_q;
	reg [6:0] dsp_div_q;
	reg [6:0] conv_div_q;
	reg [6:0] cp_div_q;
	reg [6:0] osr_div_q;
	reg [6:0] bclk_div_q;
	reg [7:0] fclk_div_q;

	always @(posedge mclk) begin
		if (reset) begin
			frac_high_q <= `PLLCD_RST_FRAC_HIGH;
			frac_low_q  <= `PLLCD_RST_ZERO8;
			post_mult_q <= `PLLCD_RST_POST_MULT;
			dsp_div_q   <= `PLLCD_RST_DSP_DIV;
			conv_div_q  <= `PLLCD_RST_CONV_DIV;
			cp_div_q    <= `PLLCD_RST_CP_DIV;
			osr_div_q   <= `PLLCD_RST_OSR_DIV;
			bclk_div_q  <= `PLLCD_RST_BCLK_DIV;
			fclk_div_q  <= `PLLCD_RST_ZERO8;
		end else if (reg_wr) begin
			if (reg_addr == `PLLCD_OFF_FRAC_HIGH) begin
				frac_high_q <= reg_wdata[5:0];
			end else if (reg_addr == `PLLCD_OFF_FRAC_LOW) begin
				frac_low_q <= reg_wdata;
			end else if (reg_addr == `PLLCD_OFF_POST_MULT) begin
				post_mult_q <= reg_wdata[3:0];
			end else if (reg_addr == `PLLCD_OFF_DSP_DIV) begin
				dsp_div_q <= reg_wdata[6:0];
			end else if (reg_addr == `PLLCD_OFF_CONV_DIV) begin
				conv_div_q <= reg_wdata[6:0];
			end else if (reg_addr == `PLLCD_OFF_CP_DIV) begin
				cp_div_q <= reg_wdata[6:0];
			end else if (reg_addr == `PLLCD_OFF_OSR_DIV) begin
				osr_div_q <= reg_wdata[6:0];
			end else if (reg_addr == `PLLCD_OFF_BCLK_DIV) begin
				bclk_div_q <= reg_wdata[6:0];
			end else if (reg_addr == `PLLCD_OFF_FCLK_DIV) begin
				fclk_div_q <= reg_wdata;
			end
		end
	end

	// Read data is registered; reserved bits and unmapped offsets read as zero.
	always @(posedge mclk) begin
		if (reset) begin
			reg_rdata <= `PLLCD_RST_ZERO8;
		end else if (reg_rd) begin
			if (reg_addr == `PLLCD_OFF_FRAC_HIGH) begin
				reg_rdata <= {2'b00, frac_high_q};
			end else if (reg_addr == `PLLCD_OFF_FRAC_LOW) begin
				reg_rdata <= frac_low_q;
			end else if (reg_addr == `PLLCD_OFF_POST_MULT) begin
				reg_rdata <= {4'h0, post_mult_q};
			end else if (reg_addr == `PLLCD_OFF_DSP_DIV) begin
				reg_rdata <= {1'b0, dsp_div_q};
			end else if (reg_addr == `PLLCD_OFF_CONV_DIV) begin
				reg_rdata <= {1'b0, conv_div_q};
			end else if (reg_addr == `PLLCD_OFF_CP_DIV) begin
				reg_rdata <= {1'b0, cp_div_q};
			end else if (reg_addr == `PLLCD_OFF_OSR_DIV) begin
				reg_rdata <= {1'b0, osr_div_q};
			end else if (reg_addr == `PLLCD_OFF_BCLK_DIV) begin
				reg_rdata <= {1'b0, bclk_div_q};
			end else if (reg_addr == `PLLCD_OFF_FCLK_DIV) begin
				reg_rdata <= fclk_div_q;
			end else begin
				reg_rdata <= `PLLCD_RST_ZERO8;
			end
		end
	end

	// ****************************************************************
	// Effective factors
	// ****************************************************************
	wire        auto_on   = ~auto_clock_setting_disable;
	wire [13:0] frac_prog = {frac_high_q, frac_low_q};
	wire [6:0]  dsp_sel   = auto_on ? AUTO_DSP_DIV  : dsp_div_q;
	wire [6:0]  conv_sel  = auto_on ? AUTO_CONV_DIV : conv_div_q;
	wire [6:0]  cp_sel    = auto_on ? AUTO_CP_DIV   : cp_div_q;
	wire [6:0]  osr_sel   = auto_on ? AUTO_OSR_DIV  : osr_div_q;
	wire [6:0]  bclk_sel  = auto_on ? AUTO_BCLK_DIV : bclk_div_q;
	wire [7:0]  fclk_sel  = auto_on ? AUTO_FCLK_DIV : fclk_div_q;
	wire [5:0]  j_sel     = auto_on ? auto_integer_mult : pll_integer_mult;
	wire [3:0]  p_sel     = auto_on ? auto_pre_divide : pll_pre_divide;
	wire [3:0]  r_sel     = auto_on ? AUTO_POST_MULT : post_mult_q;
	wire [13:0] d_sel     = auto_on ? AUTO_FRAC : frac_prog;
	wire [31:0] j_scaled  = {26'h0, j_sel} * `PLLCD_FRAC_SCALE;
	wire [31:0] jd_sum    = j_scaled + {18'h0, d_sel};
	wire [31:0] jdr       = jd_sum * {27'h0, {1'b0, r_sel} + 5'h01};

	always @(posedge mclk) begin
		if (reset) begin
			eff_integer_mult <= `PLLCD_RST_INT_MULT;
			eff_pre_divide   <= 5'h01;
			eff_post_mult    <= 5'h01;
			eff_fraction     <= 14'h0000;
			fraction_illegal <= 1'b0;
			pll_mult_x10000  <= 32'h0000_0000;
		end else begin
			eff_integer_mult <= j_sel;
			eff_pre_divide   <= {1'b0, p_sel} + 5'h01;
			eff_post_mult    <= {1'b0, r_sel} + 5'h01;
			eff_fraction     <= d_sel;
			fraction_illegal <= (d_sel > `PLLCD_FRAC_MAX);
			pll_mult_x10000  <= jdr;
		end
	end

	// ****************************************************************
	// Divider chain
	// ****************************************************************
	// Each clock output is a one-cycle pulse every (setting + 1) ticks: src_clk_en ticks, but mclk cycles for master_bitclk and bit clocks for master_frameclk.
	reg [6:0] dsp_cnt_q;
	reg [6:0] conv_cnt_q;
	reg [6:0] cp_cnt_q;
	reg [6:0] osr_cnt_q;
	reg [6:0] bclk_cnt_q;
	reg [7:0] fclk_cnt_q;
	reg       bclk_tick_q;

	function [6:0] pllcd_next7;
		input [6:0] cnt;
		input [6:0] lim;
		begin
			pllcd_next7 = (cnt >= lim) ? 7'h00 : cnt + 7'h01;
		end
	endfunction

	always @(posedge mclk) begin
		if (reset) begin
			dsp_cnt_q          <= 7'h00;
			conv_cnt_q         <= 7'h00;
			cp_cnt_q           <= 7'h00;
			osr_cnt_q          <= 7'h00;
			bclk_cnt_q         <= 7'h00;
			fclk_cnt_q         <= `PLLCD_RST_ZERO8;
			bclk_tick_q        <= 1'b0;
			dsp_clk_en         <= 1'b0;
			converter_clk_en   <= 1'b0;
			charge_pump_clk_en <= 1'b0;
			oversample_clk_en  <= 1'b0;
			master_bitclk      <= 1'b0;
			master_frameclk    <= 1'b0;
		end else begin
			dsp_clk_en         <= src_clk_en && (dsp_cnt_q >= dsp_sel);
			converter_clk_en   <= src_clk_en && (conv_cnt_q >= conv_sel);
			charge_pump_clk_en <= src_clk_en && (cp_cnt_q >= cp_sel);
			oversample_clk_en  <= src_clk_en && (osr_cnt_q >= osr_sel);
			if (src_clk_en) begin
				dsp_cnt_q  <= pllcd_next7(dsp_cnt_q, dsp_sel);
				conv_cnt_q <= pllcd_next7(conv_cnt_q, conv_sel);
				cp_cnt_q   <= pllcd_next7(cp_cnt_q, cp_sel);
				osr_cnt_q  <= pllcd_next7(osr_cnt_q, osr_sel);
			end
			if (master_mode) begin
				bclk_cnt_q    <= pllcd_next7(bclk_cnt_q, bclk_sel);
				bclk_tick_q   <= (bclk_cnt_q >= bclk_sel);
				master_bitclk <= (bclk_cnt_q >= bclk_sel);
				if (bclk_tick_q) begin
					fclk_cnt_q      <= (fclk_cnt_q >= fclk_sel) ? 8'h00 : fclk_cnt_q + 8'h01;
				end
				master_frameclk <= bclk_tick_q && (fclk_cnt_q >= fclk_sel);
			end else begin
				bclk_cnt_q      <= 7'h00;
				fclk_cnt_q      <= `PLLCD_RST_ZERO8;
				bclk_tick_q     <= 1'b0;
				master_bitclk   <= 1'b0;
				master_frameclk <= 1'b0;
			end
		end
	end

endmodule // pllcd_clock_config

// [hw/pllcd_defs.vh]
// Register offsets, reset values and fraction limit and scale for the PLL and clock divider block.
// Assumes inclusion by the design file only; holds definitions and no logic.
`ifndef PLLCD_DEFS_VH
`define PLLCD_DEFS_VH

`define PLLCD_OFF_FRAC_HIGH    8'h16
`define PLLCD_OFF_FRAC_LOW     8'h17
`define PLLCD_OFF_POST_MULT    8'h18
`define PLLCD_OFF_DSP_DIV      8'h1B
`define PLLCD_OFF_CONV_DIV     8'h1C
`define PLLCD_OFF_CP_DIV       8'h1D
`define PLLCD_OFF_OSR_DIV      8'h1E
`define PLLCD_OFF_BCLK_DIV     8'h20
`define PLLCD_OFF_FCLK_DIV     8'h21

`define PLLCD_RST_ZERO8        8'h00
`define PLLCD_RST_FRAC_HIGH    6'h00
`define PLLCD_RST_POST_MULT    4'h0
`define PLLCD_RST_DSP_DIV      7'h00
`define PLLCD_RST_BCLK_DIV     7'h00
`define PLLCD_RST_CONV_DIV     7'h01
`define PLLCD_RST_CP_DIV       7'h01
`define PLLCD_RST_OSR_DIV      7'h01
`define PLLCD_RST_INT_MULT     6'h08
`define PLLCD_FRAC_MAX         14'h270F
`define PLLCD_FRAC_SCALE       32'h0000_2710

`endif

// [sim/pllcd_clock_config_sva.sv]
// Port assertions for the PLL factor and clock divider block.
// Assumes one mclk domain; bound onto pllcd_clock_config.
`timescale 1ns/1ps
module pllcd_clock_config_sva (
	input wire        mclk,
	input wire        reset,
	input wire        reg_rd,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_rdata,
	input wire        auto_clock_setting_disable,
	input wire        master_mode,
	input wire        src_clk_en,
	input wire [5:0]  pll_integer_mult,
	input wire [3:0]  pll_pre_divide,
	input wire [5:0]  auto_integer_mult,
	input wire [3:0]  auto_pre_divide,
	input wire [5:0]  eff_integer_mult,
	input wire [4:0]  eff_pre_divide,
	input wire [4:0]  eff_post_mult,
	input wire [13:0] eff_fraction,
	input wire        fraction_illegal,
	input wire [31:0] pll_mult_x10000,
	input wire        dsp_clk_en,
	input wire        master_bitclk,
	input wire        master_frameclk
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	a_frac_limit: assert property (fraction_illegal == (eff_fraction > 14'h270F))
		else $error("fraction flag wrong");
	a_j_select: assert property (!$past(reset) |-> eff_integer_mult ==
		($past(auto_clock_setting_disable) ? $past(pll_integer_mult) : $past(auto_integer_mult)))
		else $error("integer factor wrong");
	a_p_select: assert property (!$past(reset) |-> eff_pre_divide == 5'h01 +
		($past(auto_clock_setting_disable) ? $past(pll_pre_divide) : $past(auto_pre_divide)))
		else $error("pre-divider wrong");
	a_post_range: assert property (eff_post_mult != 5'h00 && eff_post_mult <= 5'h10)
		else $error("post multiplier out of range");
	a_mult_product: assert property (!$past(reset) |-> pll_mult_x10000 ==
		(eff_integer_mult * 32'h2710 + eff_fraction) * eff_post_mult)
		else $error("overall factor wrong");
	a_master_off: assert property (!master_mode && !$past(master_mode) |->
		!master_bitclk && !master_frameclk) else $error("master clock while off");
	a_dsp_tick: assert property (dsp_clk_en |-> $past(src_clk_en))
		else $error("divider pulse without tick");
	a_rdata_hold: assert property (!$past(reg_rd) && !$past(reset) |-> $stable(reg_rdata))
		else $error("read data moved");
	a_unmapped_read: assert property (reg_rd && reg_addr == 8'h19 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	c_frame: cover property (master_frameclk);
	c_illegal: cover property (fraction_illegal);
	c_auto_dsp: cover property (!auto_clock_setting_disable ##1 dsp_clk_en);
endmodule // pllcd_clock_config_sva

bind pllcd_clock_config pllcd_clock_config_sva u_sva (.mclk, .reset, .reg_rd, .reg_addr,
	.reg_rdata, .auto_clock_setting_disable, .master_mode, .src_clk_en, .pll_integer_mult,
	.pll_pre_divide, .auto_integer_mult, .auto_pre_divide, .eff_integer_mult, .eff_pre_divide,
	.eff_post_mult, .eff_fraction, .fraction_illegal, .pll_mult_x10000, .dsp_clk_en,
	.master_bitclk, .master_frameclk);

// [sim/pllcd_clock_config_test.sv]
// Self-checking bench for the PLL factor and clock divider registers.
// Assumes design and checker compiled first; inputs change on falling mclk.
`timescale 1ns/1ps
module pllcd_clock_config_test;
	localparam [6:0]  BA = 7'h05;
	localparam [71:0] OFFS = 72'h16_17_18_1B_1C_1D_1E_20_21;
	localparam [71:0] RSTV = 72'h00_00_00_00_01_01_01_00_00;
	localparam [71:0] MASK = 72'h3F_FF_0F_7F_7F_7F_7F_7F_FF;
	reg         mclk, reset, reg_wr, reg_rd, auto_clock_setting_disable, master_mode, src_clk_en;
	reg  [7:0]  reg_addr, reg_wdata;
	reg  [5:0]  pll_integer_mult, auto_integer_mult;
	reg  [3:0]  pll_pre_divide, auto_pre_divide;
	wire [7:0]  reg_rdata;
	wire [5:0]  eff_integer_mult;
	wire [4:0]  eff_pre_divide, eff_post_mult;
	wire [13:0] eff_fraction;
	wire [31:0] pll_mult_x10000;
	wire        fraction_illegal, dsp_clk_en, converter_clk_en, charge_pump_clk_en;
	wire        oversample_clk_en, master_bitclk, master_frameclk;
	wire [5:0]  pulses = {master_frameclk, master_bitclk, oversample_clk_en,
		charge_pump_clk_en, converter_clk_en, dsp_clk_en};
	integer     n_mismatch, tests_run, i;

	pllcd_clock_config #(.AUTO_BCLK_DIV(BA)) dut (
		.mclk                       (mclk),
		.reset                      (reset),
		.reg_wr                     (reg_wr),
		.reg_rd                     (reg_rd),
		.reg_addr                   (reg_addr),
		.reg_wdata                  (reg_wdata),
		.reg_rdata                  (reg_rdata),
		.auto_clock_setting_disable (auto_clock_setting_disable),
		.master_mode                (master_mode),
		.src_clk_en                 (src_clk_en),
		.pll_integer_mult           (pll_integer_mult),
		.pll_pre_divide             (pll_pre_divide),
		.auto_integer_mult          (auto_integer_mult),
		.auto_pre_divide            (auto_pre_divide),
		.eff_integer_mult           (eff_integer_mult),
		.eff_pre_divide             (eff_pre_divide),
		.eff_post_mult              (eff_post_mult),
		.eff_fraction               (eff_fraction),
		.fraction_illegal           (fraction_illegal),
		.pll_mult_x10000            (pll_mult_x10000),
		.dsp_clk_en                 (dsp_clk_en),
		.converter_clk_en           (converter_clk_en),
		.charge_pump_clk_en         (charge_pump_clk_en),
		.oversample_clk_en          (oversample_clk_en),
		.master_bitclk              (master_bitclk),
		.master_frameclk            (master_frameclk)
	);

	// ****************
	// Access tasks.
	// ****************
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge mclk);
			{reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
			@(negedge mclk);
			reg_wr = 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			@(negedge mclk);
			{reg_rd, reg_addr} = {1'b1, a};
			@(negedge mclk);
			reg_rd = 1'b0;
			chk(reg_rdata, e);
		end
	endtask
	// Counts pulses of one divider output over a window of whole periods.
	task cnt(input integer b, input integer w, input [31:0] e);
		integer k, n;
		begin
			n = 0;
			for (k = 0; k < w; k = k + 1) begin
				@(negedge mclk);
				n = n + pulses[b];
			end
			chk(n, e);
		end
	endtask
	task give_verdict;
		begin
			$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
			if (n_mismatch == 0 && tests_run > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#2000000;
		n_mismatch = n_mismatch + 1;
		give_verdict;
	end
	initial begin
		{n_mismatch, tests_run} = 64'h0;
		{reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 16'h0000};
		{auto_clock_setting_disable, master_mode, src_clk_en} = 3'h7;
		{pll_integer_mult, pll_pre_divide, auto_integer_mult, auto_pre_divide} =
			{6'h3F, 4'hE, 6'h11, 4'h2};
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		rd(8'h19, 8'h00);
		for (i = 0; i < 9; i = i + 1)
			rd(OFFS[71-8*i -: 8], RSTV[71-8*i -: 8]);
		for (i = 0; i < 9; i = i + 1) begin
			wr(OFFS[71-8*i -: 8], 8'hFF);
			rd(OFFS[71-8*i -: 8], MASK[71-8*i -: 8]);
		end
		wr(8'h16, 8'h27);
		wr(8'h17, 8'h0F);
		repeat (3) @(negedge mclk);
		chk(eff_fraction, 14'h270F);
		chk(fraction_illegal, 1'b0);
		chk(eff_post_mult, 5'h10);
		chk(eff_integer_mult, 6'h3F);
		chk(eff_pre_divide, 5'h0F);
		chk(pll_mult_x10000, 32'h009C_3FF0);
		wr(8'h17, 8'h10);
		repeat (2) @(negedge mclk);
		chk(fraction_illegal, 1'b1);
		auto_clock_setting_disable = 1'b0;
		repeat (8) @(negedge mclk);
		chk({eff_integer_mult, eff_pre_divide, eff_post_mult}, 16'h4461);
		chk(eff_fraction, 14'h0000);
		cnt(4, 60, 60 / (BA + 1));
		cnt(0, 60, 30);
		auto_clock_setting_disable = 1'b1;
		for (i = 3; i < 8; i = i + 1) begin
			wr(OFFS[71-8*i -: 8], 8'h04);
			repeat (6) @(negedge mclk);
			cnt(i - 3, 50, 10);
		end
		wr(8'h21, 8'h01);
		repeat (12) @(negedge mclk);
		cnt(5, 100, 10);
		wr(8'h21, 8'h00);
		repeat (12) @(negedge mclk);
		cnt(5, 50, 10);
		wr(8'h20, 8'h7F);
		repeat (130) @(negedge mclk);
		cnt(4, 256, 2);
		{src_clk_en, master_mode} = 2'h0;
		repeat (3) @(negedge mclk);
		cnt(0, 20, 0);
		cnt(4, 20, 0);
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		reset = 1'b0;
		rd(8'h1C, 8'h01);
		give_verdict;
	end
endmodule // pllcd_clock_config_test
